//--- hw/wkt_top.sv
// wake-up countdown timer: register slave, slow clock capture, countdown and flags
`timescale 1ns/1ps
module wkt_top (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_rst_n,
    input  wire logic [wkt_pkg::ADDR_W-1:0]   i_address,
    input  wire logic                         i_read,
    input  wire logic                         i_write,
    input  wire logic [wkt_pkg::DATA_W-1:0]   i_writedata,
    input  wire logic [3:0]                   i_byteenable,
    output logic      [wkt_pkg::DATA_W-1:0]   o_readdata,
    output logic                              o_waitrequest,
    input  wire logic                         i_rc_slow_osc,
    input  wire logic                         i_xtal_slow_osc,
    input  wire logic                         i_rc_cal_done,
    output wkt_pkg::wkt_osc_ctl_t             o_osc_ctl,
    output logic                              o_retention_power_en,
    output logic                              o_rc_cal_enable,
    output logic                              o_wake_req,
    output logic                              o_irq
);
    import wkt_pkg::*;

    //==========================================================================
    // register state
    wkt_cfg_hi_t      cfg_hi;
    logic [7:0]       cfg_lo;
    logic [7:0]       reload_hi_pending;
    logic [15:0]      reload;
    logic             cal_en;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic             ack;
    logic [31:0]      readdata;

    //==========================================================================
    // bus decode: one wait cycle per access, the answer comes on the second edge
    logic       req;
    logic       wr_fire;
    logic       wr_ok;
    logic [7:0] wbyte;
    logic       hit_cfg_hi;
    logic       hit_cfg_lo;
    logic       hit_rld_hi;
    logic       hit_rld_lo;
    logic       hit_flag;
    logic       hit_status;
    logic       hit_istat;
    logic       hit_imask;

    assign req           = i_read || i_write;
    assign o_waitrequest = req && !ack;
    assign wr_fire       = i_write && ack;
    assign wr_ok         = wr_fire && i_byteenable[0];
    assign wbyte         = i_writedata[7:0];
    assign hit_cfg_hi    = wkt_hit(i_address, IDX_CFG_HI);
    assign hit_cfg_lo    = wkt_hit(i_address, IDX_CFG_LO);
    assign hit_rld_hi    = wkt_hit(i_address, IDX_RLD_HI);
    assign hit_rld_lo    = wkt_hit(i_address, IDX_RLD_LO);
    assign hit_flag      = wkt_hit(i_address, IDX_FLAG_CAL);
    assign hit_status    = wkt_hit(i_address, IDX_STATUS);
    assign hit_istat     = wkt_hit(i_address, IDX_IRQ_STAT);
    assign hit_imask     = wkt_hit(i_address, IDX_IRQ_MASK);

    logic clear_write;
    logic reload_write;
    assign clear_write  = wr_ok && hit_flag && wbyte[FC_CLEAR];
    assign reload_write = wr_ok && hit_rld_lo;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    //==========================================================================
    // slow oscillator capture: both pins pass two flops before any use
    logic [1:0] rc_sync;
    logic [1:0] xtal_sync;
    logic [1:0] cal_sync;
    logic       slow_prev;
    logic       slow_level;
    logic       slow_edge;
    logic       cal_done_s;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rc_sync   <= 2'h0;
            xtal_sync <= 2'h0;
            cal_sync  <= 2'h0;
            slow_prev <= 1'b0;
        end else begin
            rc_sync   <= {rc_sync[0], i_rc_slow_osc};
            xtal_sync <= {xtal_sync[0], i_xtal_slow_osc};
            cal_sync  <= {cal_sync[0], i_rc_cal_done};
            slow_prev <= slow_level;
        end
    end

    // source switch may add one spurious edge, harmless against a 32 kHz period
    assign slow_level = cfg_lo[LO_SRC_SEL] ? rc_sync[1] : xtal_sync[1];
    assign slow_edge  = slow_level && !slow_prev;
    assign cal_done_s = cal_en && cal_sync[1];

    //==========================================================================
    // timer runs only while the selected oscillator is switched on
    logic timer_on;
    logic tick;
    assign timer_on = cfg_lo[LO_SRC_SEL] ? cfg_lo[LO_RC_EN] : cfg_lo[LO_XTAL_EN];

    wkt_tick_divider u_div (
        .i_sys_clk   (i_sys_clk),
        .i_rst_n     (i_rst_n),
        .i_enable    (timer_on),
        .i_slow_edge (slow_edge),
        .i_divider   (cfg_hi.divider),
        .o_tick      (tick)
    );

    //==========================================================================
    // configuration and reload registers, write only from the bus side
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            cfg_hi            <= wkt_cfg_hi_t'(RST_BYTE);
            cfg_lo            <= RST_BYTE;
            reload_hi_pending <= RST_BYTE;
            reload            <= RST_RELOAD;
            cal_en            <= 1'b0;
            irq_mask          <= RST_MASK;
        end else begin
            if (wr_ok && hit_cfg_hi) begin
                cfg_hi <= wkt_cfg_hi_t'(wbyte);
            end
            if (wr_ok && hit_cfg_lo) begin
                cfg_lo <= wbyte;
            end
            if (wr_ok && hit_rld_hi) begin
                reload_hi_pending <= wbyte;
            end
            if (reload_write) begin
                reload <= {reload_hi_pending, wbyte};
            end
            if (wr_ok && hit_flag) begin
                cal_en <= wbyte[FC_CAL_EN];
            end
            if (wr_ok && hit_imask) begin
                irq_mask <= wbyte[IRQ_W-1:0];
            end
        end
    end

    //==========================================================================
    // down-counter: a reload write restarts the count from the new value
    logic [15:0] count;
    logic [15:0] next_count;
    logic        at_zero;
    logic        live_event;
    logic        live_prev;
    logic        timeout_pulse;

    assign at_zero       = (count == 16'h0000);
    assign next_count    = reload_write ? {reload_hi_pending, wbyte} :
                           at_zero      ? reload :
                                          count - 16'h0001;
    assign live_event    = timer_on && at_zero;
    assign timeout_pulse = live_event && !live_prev;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            count     <= RST_RELOAD;
            live_prev <= 1'b0;
        end else begin
            live_prev <= live_event;
            if (reload_write || (tick && timer_on)) begin
                count <= next_count;
            end
        end
    end

    //==========================================================================
    // latched flags, a new event beats a clear in the same cycle
    logic latched;
    logic cold_start;
    logic cal_prev;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            latched    <= 1'b0;
            cold_start <= 1'b1;
            cal_prev   <= 1'b0;
        end else begin
            cal_prev <= cal_done_s;
            if (timeout_pulse) begin
                latched <= 1'b1;
            end else if (clear_write) begin
                latched <= 1'b0;
            end
            if (clear_write) begin
                cold_start <= 1'b0;
            end
        end
    end

    //==========================================================================
    // interrupt status, write one to clear, set wins
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    assign irq_set[IRQ_TIMEOUT] = timeout_pulse;
    assign irq_set[IRQ_CAL]     = cal_done_s && !cal_prev;
    assign irq_clr              = (wr_ok && hit_istat) ? wbyte[IRQ_W-1:0] : {IRQ_W{1'b0}};

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            irq_stat <= {IRQ_W{1'b0}};
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_set;
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    //==========================================================================
    // read mux: write-only registers and unmapped addresses read zero
    logic [7:0]  status_byte;
    logic [31:0] next_readdata;
    always_comb begin
        status_byte              = 8'h00;
        status_byte[ST_CAL_DONE] = cal_done_s;
        status_byte[ST_XTAL_OUT] = xtal_sync[1];
        status_byte[ST_COLD]     = cold_start;
        status_byte[ST_LATCHED]  = latched;
        status_byte[ST_LIVE]     = live_event;
    end

    assign next_readdata = hit_status ? {24'h000000, status_byte} :
                           hit_flag   ? {30'h00000000, cal_en, 1'b0} :
                           hit_istat  ? {30'h00000000, irq_stat} :
                           hit_imask  ? {30'h00000000, irq_mask} :
                                        32'h00000000;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            readdata <= 32'h00000000;
        end else if (i_read && !ack) begin
            readdata <= next_readdata;
        end
    end

    //==========================================================================
    // outputs toward the analog side and the power controller
    logic wake_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= timeout_pulse && cfg_lo[LO_ARM];
        end
    end

    assign o_readdata           = readdata;
    assign o_wake_req           = wake_q;
    assign o_osc_ctl.rc_enable   = cfg_lo[LO_RC_EN];
    assign o_osc_ctl.xtal_enable = cfg_lo[LO_XTAL_EN];
    assign o_osc_ctl.source_rc   = cfg_lo[LO_SRC_SEL];
    assign o_osc_ctl.rc_trim     = cfg_hi.trim;
    assign o_retention_power_en = cfg_lo[LO_RET_PWR];
    assign o_rc_cal_enable      = cal_en;

    //==========================================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // a tick at zero with a nonzero reload must drop the live bit, it is never held
    property p_live;
        (status_byte[ST_LIVE] && tick && reload != 16'h0000 && !reload_write) |=> !status_byte[ST_LIVE];
    endproperty
    a_live: assert property (p_live) else $error("live event held past zero");

    property p_latch_set;
        timeout_pulse |=> latched;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("timeout not latched");

    property p_latch_hold;
        (latched && !clear_write) |=> latched;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");

    property p_clear;
        (clear_write && !timeout_pulse) |=> (!latched && !cold_start);
    endproperty
    a_clear: assert property (p_clear) else $error("flag clear ignored");

    property p_wake_arm;
        o_wake_req |-> ($past(cfg_lo[LO_ARM]) && $past(timeout_pulse));
    endproperty
    a_wake_arm: assert property (p_wake_arm) else $error("wake without arm or event");

    property p_high_pending;
        (wr_ok && hit_rld_hi) |=> $stable(reload);
    endproperty
    a_high_pending: assert property (p_high_pending) else $error("high byte applied early");

    property p_reload_pair;
        reload_write |=> (reload == {$past(reload_hi_pending), $past(wbyte)});
    endproperty
    a_reload_pair: assert property (p_reload_pair) else $error("reload bytes misplaced");

    property p_reload_zero;
        (tick && timer_on && at_zero && !reload_write) |=> (count == $past(reload));
    endproperty
    a_reload_zero: assert property (p_reload_zero) else $error("no reload at zero");

    property p_cal_done;
        !cal_en |-> !status_byte[ST_CAL_DONE];
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("cal done shown while disabled");

    property p_bus_wait;
        (req && !ack) |-> o_waitrequest ##1 !o_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait) else $error("bus answer not on second edge");

    c_timeout: cover property (timeout_pulse && cfg_lo[LO_ARM]);
    c_reload_run: cover property (tick && at_zero && reload != 16'h0000);
    c_clear_race: cover property (timeout_pulse && clear_write);
    c_irq: cover property (o_irq);
endmodule

//--- hw/wkt_pkg.sv
// wake-up countdown timer: register map, field layout, carrier types and shared decoders
//==============================================================================
// Behaviour
// - the countdown steps on the slow clock divided by 1, 4, 8, 16, 128, 1024, 8192 or 65536 as the 3-bit divider code 0..7 selects.
// - the clock source select bit picks the RC slow oscillator when 1 and the crystal slow oscillator when 0.
// - the 4-bit coarse trim field is driven to the RC oscillator, where 1101 is nominal, 0000 is +83 percent and 0111 is -66 percent.
// - separate enable bits switch the RC and the crystal slow oscillators on when 1 and off when 0.
// - the retention memory power bit keeps the battery-backed memory powered during sleep when 1 and unpowered when 0.
// - the arm bit lets a timeout wake the chip when 1 and blocks any wake-up when 0.
// - a wake-up event is raised when the timer unit runs and the down-counter has reached zero.
// - the reload value takes its bits 15 to 8 from the high reload register.
// - the reload value takes its bits 7 to 0 from the low reload register.
// - a high reload byte waits pending and is applied only when the low reload byte is written.
// - the calibration enable bit starts RC oscillator calibration when 1 and keeps it off when 0.
// - writing 1 to the flag clear bit clears the latched timeout flag and the cold start flag, and 0 does nothing.
// - the live timeout status bit reads 1 only while the down-counter sits at zero.
// - the latched timeout flag is set by a timeout event and stays set until the flag clear bit clears it.
// - with calibration enabled the calibration done bit reads 1 once calibration finished and 0 while it runs.
package wkt_pkg;

    //==========================================================================
    // bus geometry
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int IDX_W  = 12;

    //==========================================================================
    // register indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CFG_HI   = 12'h30C;
    localparam logic [IDX_W-1:0] IDX_CFG_LO   = 12'h30D;
    localparam logic [IDX_W-1:0] IDX_RLD_HI   = 12'h30E;
    localparam logic [IDX_W-1:0] IDX_RLD_LO   = 12'h30F;
    localparam logic [IDX_W-1:0] IDX_FLAG_CAL = 12'h310;
    localparam logic [IDX_W-1:0] IDX_STATUS   = 12'h311;
    localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 12'h330;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h331;

    //==========================================================================
    // field positions
    localparam int LO_RC_EN    = 6;
    localparam int LO_XTAL_EN  = 5;
    localparam int LO_SRC_SEL  = 4;
    localparam int LO_RET_PWR  = 3;
    localparam int LO_ARM      = 0;
    localparam int FC_CAL_EN   = 1;
    localparam int FC_CLEAR    = 0;
    localparam int ST_CAL_DONE = 5;
    localparam int ST_XTAL_OUT = 3;
    localparam int ST_COLD     = 2;
    localparam int ST_LATCHED  = 1;
    localparam int ST_LIVE     = 0;
    localparam int IRQ_W       = 2;
    localparam int IRQ_TIMEOUT = 0;
    localparam int IRQ_CAL     = 1;

    //==========================================================================
    // reset values
    localparam logic [7:0]       RST_BYTE   = 8'h00;
    localparam logic [15:0]      RST_RELOAD = 16'h0000;
    localparam logic [IRQ_W-1:0] RST_MASK   = 2'h0;

    //==========================================================================
    // carrier types
    typedef struct packed {
        logic       reserved;
        logic [3:0] trim;
        logic [2:0] divider;
    } wkt_cfg_hi_t;

    typedef struct packed {
        logic       rc_enable;
        logic       xtal_enable;
        logic       source_rc;
        logic [3:0] rc_trim;
    } wkt_osc_ctl_t;

    //==========================================================================
    // shared decoders
    // terminal count of the tick divider, one less than the division ratio
    function automatic logic [15:0] wkt_divider_tc(input logic [2:0] code);
        case (code)
            3'h0:    return 16'h0000;
            3'h1:    return 16'h0003;
            3'h2:    return 16'h0007;
            3'h3:    return 16'h000F;
            3'h4:    return 16'h007F;
            3'h5:    return 16'h03FF;
            3'h6:    return 16'h1FFF;
            default: return 16'hFFFF;
        endcase
    endfunction

    function automatic logic wkt_hit(input logic [ADDR_W-1:0] addr, input logic [IDX_W-1:0] idx);
        return addr == {idx, 2'h0};
    endfunction

endpackage

//--- hw/wkt_tick_divider.sv
// wake-up countdown timer: slow clock edge to countdown tick divider
`timescale 1ns/1ps
module wkt_tick_divider (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_enable,
    input  wire logic       i_slow_edge,
    input  wire logic [2:0] i_divider,
    output logic            o_tick
);
    import wkt_pkg::*;

    logic [15:0] count;
    logic [15:0] tc;
    logic        wrap;

    assign tc   = wkt_divider_tc(i_divider);
    assign wrap = i_slow_edge && (count >= tc);

    //==========================================================================
    // divider counter, held at zero while stopped so a restart is a clean period
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || !i_enable) begin
            count  <= 16'h0000;
            o_tick <= 1'b0;
        end else begin
            o_tick <= wrap;
            if (wrap) begin
                count <= 16'h0000;
            end else if (i_slow_edge) begin
                count <= count + 16'h0001;
            end
        end
    end

    //==========================================================================
    // checks
    property p_div_one;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_enable && i_slow_edge && i_divider == 3'h0) |=> o_tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

    property p_tick_needs_edge;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_tick |-> $past(i_slow_edge);
    endproperty
    a_tick_needs_edge: assert property (p_tick_needs_edge) else $error("tick without slow edge");
endmodule

//--- tb/wkt_top_tb.sv
// self-checking random testbench for the wake-up countdown timer
`timescale 1ns/1ps
module wkt_top_tb;
    import wkt_pkg::*;
    //==========================================================================
    // signals
    logic               i_sys_clk = 1'b0;
    logic               i_rst_n = 1'b0;
    logic [ADDR_W-1:0]  i_address = '0;
    logic               i_read = 1'b0;
    logic               i_write = 1'b0;
    logic [DATA_W-1:0]  i_writedata = '0;
    logic [3:0]         i_byteenable = 4'h0;
    logic [DATA_W-1:0]  o_readdata;
    logic               o_waitrequest;
    logic               i_rc_slow_osc = 1'b0;
    logic               i_xtal_slow_osc = 1'b0;
    logic               i_rc_cal_done = 1'b0;
    wkt_osc_ctl_t       o_osc_ctl;
    logic               o_retention_power_en;
    logic               o_rc_cal_enable;
    logic               o_wake_req;
    logic               o_irq;
    int                 fail_count = 0;
    int                 check_count = 0;
    int                 cyc = 0;
    int                 n;
    logic [31:0]        q;
    logic [3:0]         trim;
    logic [7:0]         r;
    logic [3:0]         be = 4'hF;

    wkt_top DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_rc_slow_osc(i_rc_slow_osc), .i_xtal_slow_osc(i_xtal_slow_osc),
        .i_rc_cal_done(i_rc_cal_done), .o_osc_ctl(o_osc_ctl), .o_retention_power_en(o_retention_power_en),
        .o_rc_cal_enable(o_rc_cal_enable), .o_wake_req(o_wake_req), .o_irq(o_irq));

    //==========================================================================
    // clock, 4 ns period
    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end

    // slow oscillators: half periods of 5 and 7 cycles so a wrong source shows in the period
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc % 5 == 4) i_rc_slow_osc <= ~i_rc_slow_osc;
        if (cyc % 7 == 6) i_xtal_slow_osc <= ~i_xtal_slow_osc;
    end

    //==========================================================================
    // helpers
    function automatic int div_of(input int c);
        return (c == 0) ? 1 : (c < 4) ? (1 << (c + 1)) : (1 << (3 * c - 5));
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one avalon transfer; request held until waitrequest is sampled low
    // no wait limit here: only the watchdog may end a stuck transfer
    task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
        i_address    <= {idx, 2'h0};
        i_write      <= wr;
        i_read       <= ~wr;
        i_writedata  <= {24'h0, d};
        i_byteenable <= be;
        @(posedge i_sys_clk);
        while (o_waitrequest !== 1'b0) begin
            @(posedge i_sys_clk);
        end
        q = o_readdata;
        i_write <= 1'b0;
        i_read  <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    // paired writes, the high byte always goes first
    task automatic cfg(input logic [7:0] hi, input logic [7:0] lo);
        bus(1, IDX_CFG_HI, hi);
        bus(1, IDX_CFG_LO, lo);
    endtask

    task automatic rld(input logic [15:0] v);
        bus(1, IDX_RLD_HI, v[15:8]);
        bus(1, IDX_RLD_LO, v[7:0]);
    endtask

    // cycles between the second and third wake pulse, so restart effects are skipped
    task automatic measure(output int m);
        int k;
        k = 0;
        repeat (2) begin
            while (o_wake_req !== 1'b1 && k < 20000) begin
                @(posedge i_sys_clk);
                k++;
            end
            @(posedge i_sys_clk);
        end
        m = 1;
        while (o_wake_req !== 1'b1 && m < 20000) begin
            @(posedge i_sys_clk);
            m++;
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // watchdog, well above the expected run of some 17k to 26k cycles
    initial begin
        repeat (90000) @(posedge i_sys_clk);
        fail_count++;
        end_sim();
    end

    //==========================================================================
    // main sequence
    initial begin
        void'($urandom(32'h7BF8C1B1));
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'hF7, 32'h04, "status after reset");
        bus(0, IDX_CFG_HI, 8'h00);
        chk(q, 32'h0, "write-only read");
        bus(0, 12'hFFF, 8'h00);
        chk(q, 32'h0, "unmapped read");
        chk({o_osc_ctl, o_retention_power_en, o_rc_cal_enable, o_wake_req, o_irq}, 32'h0, "outputs after reset");
        $display("test reset done");
        // random trim and retention bit, both oscillators on, rc source, armed
        trim = 4'($urandom);
        r    = 8'($urandom);
        cfg({1'b0, trim, 3'h0}, {4'h7, r[3], 3'h1});
        chk(o_osc_ctl, {3'h7, trim}, "osc control");
        chk(o_retention_power_en, r[3], "retention power");
        // divider codes with short random reload values
        for (int c = 0; c < 5; c++) begin
            r = 8'(1 + $urandom % 3);
            bus(1, IDX_CFG_HI, {1'b0, trim, 3'(c)});
            rld({8'h00, r});
            measure(n);
            chk(n, (r + 1) * div_of(c) * 10, "period");
        end
        $display("test divider done");
        // high reload byte waits for the low byte
        bus(1, IDX_CFG_HI, {1'b0, trim, 3'h0});
        bus(1, IDX_RLD_HI, 8'h01);
        measure(n);
        chk(n, (r + 1) * 10, "pending high byte");
        bus(1, IDX_RLD_LO, 8'h02);
        measure(n);
        chk(n, 2590, "high byte applied");
        // crystal as source
        rld(16'h0003);
        cfg({1'b0, trim, 3'h0}, 8'h21);
        measure(n);
        chk(n, 56, "crystal period");
        $display("test reload done");
        // latched flags: write 0 keeps them, write 1 clears them
        cfg({1'b0, trim, 3'h0}, 8'h00);
        bus(1, IDX_FLAG_CAL, 8'h00);
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'h07, 32'h06, "flags kept");
        bus(1, IDX_FLAG_CAL, 8'h01);
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'h06, 32'h00, "flags cleared");
        // disarmed: timeouts keep coming but no wake pulse
        rld(16'h0001);
        cfg({1'b0, trim, 3'h0}, 8'h50);
        n = 0;
        repeat (300) begin
            @(posedge i_sys_clk);
            if (o_wake_req === 1'b1) n++;
        end
        chk(n, 0, "wake while disarmed");
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'h02, 32'h02, "latched flag");
        rld(16'h0000);
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'h01, 32'h01, "live at zero");
        // interrupt: unmasked, masked, cleared
        bus(1, IDX_IRQ_MASK, 8'h01);
        chk(o_irq, 1'b1, "irq unmasked");
        bus(1, IDX_IRQ_MASK, 8'h00);
        chk(o_irq, 1'b0, "irq masked");
        cfg({1'b0, trim, 3'h0}, 8'h00);
        bus(1, IDX_IRQ_STAT, 8'h03);
        bus(1, IDX_IRQ_MASK, 8'h01);
        chk(o_irq, 1'b0, "irq cleared");
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'h01, 32'h00, "live when stopped");
        $display("test flags done");
        // a write without byte lane 0 is refused
        be = 4'hE;
        bus(1, IDX_FLAG_CAL, 8'h02);
        be = 4'hF;
        bus(0, IDX_FLAG_CAL, 8'h00);
        chk(q, 32'h0, "write without lane 0");
        // calibration enable and done
        bus(1, IDX_FLAG_CAL, 8'h02);
        chk(o_rc_cal_enable, 1'b1, "cal enable");
        i_rc_cal_done <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        bus(0, IDX_STATUS, 8'h00);
        chk(q[5], 1'b1, "cal done");
        bus(0, IDX_IRQ_STAT, 8'h00);
        chk(q, 32'h02, "cal irq status");
        bus(0, IDX_FLAG_CAL, 8'h00);
        chk(q, 32'h02, "cal readback");
        i_rc_cal_done <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        bus(0, IDX_STATUS, 8'h00);
        chk(q[5], 1'b0, "cal running");
        bus(1, IDX_FLAG_CAL, 8'h00);
        chk(o_rc_cal_enable, 1'b0, "cal off");
        $display("test calibration done");
        // reset again in mid run: the cleared cold start flag must come back
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        bus(0, IDX_STATUS, 8'h00);
        chk(q & 32'hF7, 32'h04, "status after second reset");
        chk({o_osc_ctl, o_retention_power_en, o_rc_cal_enable, o_irq}, 32'h0, "outputs after second reset");
        $display("test second reset done");
        end_sim();
    end
endmodule
